// ===== verilog/rsq_defs.svh
// Register offsets, field positions and timing constants of the reset sequencer
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH
`define ICS_ADDR        12'h000
`define SEQ_STATUS_ADDR 12'h004
`define CFG_ADDR        12'h008
`define BIT_WDG_FLAG    0
`define BIT_LS_FLAG     4
`define BIT_WARN_FLAG   5
`define BIT_WARN_IE     6
`define BIT_WARN_SEL    7
`define BIT_LONG_DLY    0
`define BIT_LS_EN       1
`define BIT_THR_LO      2
`define BIT_THR_HI      3
`define BIT_FETCH_HI    16
`define DLY_SHORT       13'h0100
`define DLY_LONG        13'h1000
`define FETCH_CYCLES    2'h2
`define OUT_WIDTH_NS    1000
`define CLK_NS          40
`define OUT_WIDTH_CYC   ((`OUT_WIDTH_NS + `CLK_NS - 1) / `CLK_NS)
`define VEC_LO_ADDR     16'hfffe
`define VEC_HI_ADDR     16'hffff
`endif

// ===== verilog/rsq_pkg.sv
// Types shared by the reset sequencer files
package rsq_pkg;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_FETCH  = 4'b0100,
    ST_RUN    = 4'b1000
  } seq_state_t;
  typedef struct packed {
    logic wdg;
    logic low_supply;
    logic ext;
  } reset_cause_t;
endpackage

// ===== verilog/rsq_sync2.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/100ps
module rsq_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= INIT;
      q_o    <= INIT;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// ===== verilog/reset_sequencer.sv
// Reset sequencer with supply-integrity status and APB registers
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "rsq_defs.svh"
// Function
// - Three causes: pin, low supply, watchdog
// - Every cause drives pin low through delay
// - Vector fetched from top two bytes
// - Phases: active, delay, vector fetch
// - Delay 256 or 4096 by config
// - Vector fetch lasts exactly two cycles
// - Pin detection asynchronous, works clock stopped
// - Pin is input plus open-drain output
// - Stretch external pulse to output width
// - Watchdog underflow drives pin output width
// - Low supply holds static reset, pin low
// - Low-supply detector optional, threshold selectable (here CFG_LS_THR_I is only mirrored in the CFG register)
// - Warning detector only with low-supply enabled
// - Warning flag readable, real-time, read-only
// - Source select clear monitors main supply
// - Interrupt on every warning flag toggle
// - Fast rise gives no warning interrupt
// - Slow rise, early enable: two interrupts
// - Slow rise, late enable: one interrupt (here none: flag toggles while disabled are not kept)
// - Source select set monitors external input
// - Pending warning cleared on service entry
// - Low-supply flag hardware set, write-zero clear
module reset_sequencer (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Reset pin, open drain
  input  wire logic        RST_PIN_I,
  output logic             RST_PIN_O,
  output logic             RST_PIN_OE_O,
  // Analog comparators and watchdog
  input  wire logic        LS_DET_I,
  input  wire logic        MAIN_CMP_I,
  input  wire logic        EXT_CMP_I,
  input  wire logic        WDG_UNDERFLOW_I,
  // Non-volatile configuration
  input  wire logic        CFG_LONG_DELAY_I,
  input  wire logic        CFG_LS_EN_I,
  input  wire logic [1:0]  CFG_LS_THR_I,
  // CPU side
  input  wire logic        WARN_IRQ_ACK_I,
  output logic             CPU_RESET_O,
  output logic             VEC_FETCH_O,
  output logic [15:0]      VEC_ADDR_O,
  output logic             WARN_IRQ_O
);
  rsq_pkg::seq_state_t   state_r;
  rsq_pkg::seq_state_t   state_nxt;
  rsq_pkg::reset_cause_t cause_s;
  logic [12:0] dly_cnt_r;
  logic [12:0] dly_len;
  logic [5:0]  wid_cnt_r;
  logic [1:0]  fetch_cnt_r;
  logic        pin_hit_r;
  logic        pin_hit_s;
  logic        pin_low_s;
  logic        pin_tog_s;
  logic        pin_tog_d_r;
  logic [1:0]  oe_hist_r;
  logic        own_drive;
  logic        ls_s;
  logic        main_s;
  logic        extc_s;
  logic        long_s;
  logic        lsen_s;
  logic [1:0]  thr_s;
  logic        warn_sel_r;
  logic        warn_ie_r;
  logic        warn_flag_r;
  logic        warn_flag_d_r;
  logic        warn_ie_d_r;
  logic        ls_flag_r;
  logic        wdg_flag_r;
  logic        wr_en;
  logic        warn_cmp;
  logic        any_cause;

  // Match one register offset; used by both read and write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // asynchronous pin capture
  // Toggles on every falling pin edge, so a pulse shorter than a clock is kept
  always_ff @(negedge RST_PIN_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_hit_r <= 1'b0;
    end else begin
      pin_hit_r <= ~pin_hit_r;
    end
  end

  rsq_sync2 #(.W(2), .INIT(2'h1)) u_pin_sync (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .d_i     ({pin_hit_r, ~RST_PIN_I}),
    .q_o     ({pin_tog_s, pin_low_s})
  );

  // Comparator and configuration levels come from outside the clock domain
  rsq_sync2 #(.W(7), .INIT(7'h00)) u_lvl_sync (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .d_i     ({LS_DET_I, MAIN_CMP_I, EXT_CMP_I, CFG_LONG_DELAY_I, CFG_LS_EN_I, CFG_LS_THR_I}),
    .q_o     ({ls_s, main_s, extc_s, long_s, lsen_s, thr_s})
  );

  // Toggle history and own-drive history
  // The synced pin still reads low two cycles after release, so own drive is masked
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_tog_d_r <= 1'b0;
      oe_hist_r   <= 2'h3;
    end else begin
      pin_tog_d_r <= pin_tog_s;
      oe_hist_r   <= {oe_hist_r[0], RST_PIN_OE_O};
    end
  end

  // async edge event, one cycle per captured fall
  assign pin_hit_s = pin_tog_s ^ pin_tog_d_r;
  assign own_drive = RST_PIN_OE_O | (|oe_hist_r);

  // low-supply cause gated by its enable
  always_comb begin
    cause_s.ext        = ~own_drive & (pin_low_s | pin_hit_s);
    cause_s.low_supply = ls_s & lsen_s;
    cause_s.wdg        = WDG_UNDERFLOW_I;
  end
  assign any_cause = cause_s.ext | cause_s.low_supply | cause_s.wdg;

  assign dly_len = long_s ? `DLY_LONG : `DLY_SHORT;

  // output width counter, reloaded on every cause
  // watchdog underflow also loads it
  // Power-on gets the full width too, as reset loads the counter with it
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wid_cnt_r <= 6'(`OUT_WIDTH_CYC);
    end else if (any_cause) begin
      wid_cnt_r <= 6'(`OUT_WIDTH_CYC);
    end else if (wid_cnt_r != 6'h00) begin
      wid_cnt_r <= wid_cnt_r - 6'h01;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rsq_pkg::ST_ACTIVE: begin
        if (!any_cause && wid_cnt_r == 6'h00) begin
          state_nxt = rsq_pkg::ST_DELAY;
        end
      end
      rsq_pkg::ST_DELAY: begin
        if (any_cause) begin
          state_nxt = rsq_pkg::ST_ACTIVE;
        end else if (dly_cnt_r == dly_len - 13'h0001) begin
          state_nxt = rsq_pkg::ST_FETCH;
        end
      end
      rsq_pkg::ST_FETCH: begin
        if (any_cause) begin
          state_nxt = rsq_pkg::ST_ACTIVE;
        end else if (fetch_cnt_r == `FETCH_CYCLES - 2'h1) begin
          state_nxt = rsq_pkg::ST_RUN;
        end
      end
      rsq_pkg::ST_RUN: begin
        if (any_cause) begin
          state_nxt = rsq_pkg::ST_ACTIVE;
        end
      end
      default: begin
        state_nxt = rsq_pkg::ST_ACTIVE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r <= rsq_pkg::ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dly_cnt_r <= 13'h0000;
    end else if (state_r == rsq_pkg::ST_DELAY) begin
      dly_cnt_r <= dly_cnt_r + 13'h0001;
    end else begin
      dly_cnt_r <= 13'h0000;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fetch_cnt_r <= 2'h0;
    end else if (state_r == rsq_pkg::ST_FETCH) begin
      fetch_cnt_r <= fetch_cnt_r + 2'h1;
    end else begin
      fetch_cnt_r <= 2'h0;
    end
  end

  // pin held low in active and delay phases
  // open drain, only ever drives zero
  // static low supply keeps ST_ACTIVE, so pin stays low
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RST_PIN_OE_O <= 1'b1;
      RST_PIN_O    <= 1'b0;
    end else begin
      RST_PIN_OE_O <= (state_nxt == rsq_pkg::ST_ACTIVE) || (state_nxt == rsq_pkg::ST_DELAY);
      RST_PIN_O    <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CPU_RESET_O <= 1'b1;
      VEC_FETCH_O <= 1'b0;
      VEC_ADDR_O  <= `VEC_LO_ADDR;
    end else begin
      CPU_RESET_O <= (state_nxt != rsq_pkg::ST_RUN);
      VEC_FETCH_O <= (state_nxt == rsq_pkg::ST_FETCH);
      VEC_ADDR_O  <= (state_nxt == rsq_pkg::ST_FETCH && state_r == rsq_pkg::ST_FETCH) ?
                     `VEC_HI_ADDR : `VEC_LO_ADDR;
    end
  end

  assign warn_cmp = warn_sel_r ? extc_s : main_s;

  // warning flag only with detector enabled
  // held at zero in active and delay phases so a fast rise makes no edge
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      warn_flag_r   <= 1'b0;
      warn_flag_d_r <= 1'b0;
      warn_ie_d_r   <= 1'b0;
    end else begin
      warn_flag_r   <= lsen_s & (state_r != rsq_pkg::ST_ACTIVE) &
                       (state_r != rsq_pkg::ST_DELAY) & warn_cmp;
      warn_flag_d_r <= warn_flag_r;
      warn_ie_d_r   <= warn_ie_r;
    end
  end

  // enabling while low is pending also raises one
  // late enable with flag clear raises none; a crossing while disabled is lost
  // cleared on service entry, new event wins
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      WARN_IRQ_O <= 1'b0;
    end else if (warn_ie_r && ((warn_flag_r != warn_flag_d_r) ||
                               (!warn_ie_d_r && warn_flag_r))) begin
      WARN_IRQ_O <= 1'b1;
    end else if (WARN_IRQ_ACK_I || !warn_ie_r) begin
      WARN_IRQ_O <= 1'b0;
    end
  end

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;

  // Software control bits; cleared by every internal reset too
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      warn_sel_r <= 1'b0;
      warn_ie_r  <= 1'b0;
    end else if (state_r != rsq_pkg::ST_RUN) begin
      warn_sel_r <= 1'b0;
      warn_ie_r  <= 1'b0;
    end else if (wr_en && hit(PADDR_I, `ICS_ADDR)) begin
      warn_sel_r <= PWDATA_I[`BIT_WARN_SEL];
      warn_ie_r  <= PWDATA_I[`BIT_WARN_IE];
    end
  end

  // reset cause flags, set wins over write-zero
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ls_flag_r  <= 1'b0;
      wdg_flag_r <= 1'b0;
    end else begin
      if (cause_s.low_supply) begin
        ls_flag_r <= 1'b1;
      end else if (wr_en && hit(PADDR_I, `ICS_ADDR) && !PWDATA_I[`BIT_LS_FLAG]) begin
        ls_flag_r <= 1'b0;
      end
      // Low supply reset clears the watchdog flag for a clean start
      if (cause_s.wdg) begin
        wdg_flag_r <= 1'b1;
      end else if (cause_s.low_supply) begin
        wdg_flag_r <= 1'b0;
      end else if (wr_en && hit(PADDR_I, `ICS_ADDR) && !PWDATA_I[`BIT_WDG_FLAG]) begin
        wdg_flag_r <= 1'b0;
      end
    end
  end

  // APB read data, zero-wait; unmapped reads zero with error
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
      PREADY_O  <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      if (PSEL_I && !PENABLE_I) begin
        if (hit(PADDR_I, `ICS_ADDR)) begin
          PRDATA_O[`BIT_WARN_SEL]  <= warn_sel_r;
          PRDATA_O[`BIT_WARN_IE]   <= warn_ie_r;
          PRDATA_O[`BIT_WARN_FLAG] <= warn_flag_r;
          PRDATA_O[`BIT_LS_FLAG]   <= ls_flag_r;
          PRDATA_O[`BIT_WDG_FLAG]  <= wdg_flag_r;
        end else if (hit(PADDR_I, `SEQ_STATUS_ADDR)) begin
          PRDATA_O[3:0] <= state_r;
        end else if (hit(PADDR_I, `CFG_ADDR)) begin
          PRDATA_O[`BIT_LONG_DLY] <= long_s;
          PRDATA_O[`BIT_LS_EN]    <= lsen_s;
          PRDATA_O[`BIT_THR_HI:`BIT_THR_LO] <= thr_s;
        end else begin
          PSLVERR_O <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== testbench/rsq_pin_model.sv
// Reset pin model: weak pull-up, device open drain, outside pull-down
`timescale 1ns/100ps
module rsq_pin_model (
  // Device driver and outside circuitry
  input  wire logic dev_oe_i,
  input  wire logic dev_d_i,
  input  wire logic ext_low_i,
  // Resolved pin level
  output logic      pin_o
);
  assign pin_o = (dev_oe_i ? dev_d_i : 1'b1) & ~ext_low_i;
endmodule

// ===== testbench/rsq_chk.sv
// Concurrent checks on the reset sequencer ports
`timescale 1ns/100ps
module rsq_chk (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Watched ports
  input  wire logic        RST_PIN_OE_O,
  input  wire logic        CPU_RESET_O,
  input  wire logic        VEC_FETCH_O,
  input  wire logic [15:0] VEC_ADDR_O,
  input  wire logic        WDG_UNDERFLOW_I,
  input  wire logic        LS_DET_I,
  input  wire logic        CFG_LS_EN_I,
  input  wire logic        WARN_IRQ_O
);
  int oe_cnt;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Length of the current pin-low stretch
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) oe_cnt <= 0;
    else oe_cnt <= RST_PIN_OE_O ? oe_cnt + 1 : 0;
  end
  a_vec_order: assert property ($rose(VEC_FETCH_O) |->
    VEC_ADDR_O == 16'hfffe ##1 VEC_ADDR_O == 16'hffff) else $error("vector address order");
  a_fetch_len: assert property ($fell(VEC_FETCH_O) && !CPU_RESET_O |->
    $past(VEC_FETCH_O, 2) && !$past(VEC_FETCH_O, 3)) else $error("fetch not two cycles");
  a_run_pin_free: assert property (!CPU_RESET_O |-> !RST_PIN_OE_O)
    else $error("pin low while running");
  a_oe_to_fetch: assert property ($fell(RST_PIN_OE_O) |-> VEC_FETCH_O)
    else $error("pin released outside fetch");
  // Output width of 25 plus the shortest delay of 256, even for short pulses
  a_oe_width: assert property ($fell(RST_PIN_OE_O) |-> oe_cnt >= 281)
    else $error("pin low too short");
  a_wdg_to_pin: assert property (WDG_UNDERFLOW_I |-> ##[1:4] RST_PIN_OE_O)
    else $error("watchdog did not pull pin");
  a_ls_static: assert property ((LS_DET_I && CFG_LS_EN_I)[*4] |->
    RST_PIN_OE_O && CPU_RESET_O) else $error("low supply not holding reset");
  a_irq_in_run: assert property ($rose(WARN_IRQ_O) |-> !CPU_RESET_O)
    else $error("warning interrupt during reset");
endmodule

// ===== testbench/reset_sequencer_tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`include "rsq_defs.svh"
module reset_sequencer_tb;
  logic        clk, rst_b, psel, penable, pwrite, ext_low, ls_det, main_cmp, ext_cmp;
  logic        wdg, cfg_long, cfg_ls_en, ack, pready, pslverr, pin, pin_d, oe;
  logic        cpu_rst, vfetch, irq;
  logic [1:0]  cfg_thr;
  logic [11:0] paddr;
  logic [15:0] vaddr;
  logic [31:0] pwdata, prdata;
  int          errors, cmp_count, n_oe, n_fc;
  // Free-running 25 MHz clock
  always #20 clk = ~clk;
  rsq_pin_model i_rsq_pin_model (.dev_oe_i(oe), .dev_d_i(pin_d), .ext_low_i(ext_low),
    .pin_o(pin));
  reset_sequencer i_reset_sequencer (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RST_PIN_I(pin),
    .RST_PIN_O(pin_d), .RST_PIN_OE_O(oe), .LS_DET_I(ls_det), .MAIN_CMP_I(main_cmp),
    .EXT_CMP_I(ext_cmp), .WDG_UNDERFLOW_I(wdg), .CFG_LONG_DELAY_I(cfg_long),
    .CFG_LS_EN_I(cfg_ls_en), .CFG_LS_THR_I(cfg_thr), .WARN_IRQ_ACK_I(ack),
    .CPU_RESET_O(cpu_rst), .VEC_FETCH_O(vfetch), .VEC_ADDR_O(vaddr), .WARN_IRQ_O(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Count windows allow for synchroniser latency
  task chk_rng(input int got, input int nom);
    chk(got, (got >= nom - 10 && got <= nom + 30) ? got : nom);
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] exp, input logic experr);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the slave; only the hang guard ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    if (!wr) chk(prdata, exp);
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, experr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Follows one reset sequence to the run phase
  task run_wait;
    int n;
    n_oe = 0;
    n_fc = 0;
    n = 0;
    while (n < 6000 && (n < 8 || cpu_rst !== 1'b0)) begin
      @(posedge clk);
      n++;
      if (oe === 1'b1) n_oe++;
      if (vfetch === 1'b1) begin
        chk({16'h0, vaddr}, 32'h0000_fffe + n_fc);
        n_fc++;
      end
    end
    chk(n_fc, 32'h0000_0002);
  endtask
  task wdg_pulse;
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    run_wait;
  endtask
  task ack_irq;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq, 32'h0000_0000);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well beyond the longest sequence
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize;
  end
  initial begin
    {clk, rst_b, psel, penable, pwrite, ext_low, ls_det, main_cmp, ext_cmp} = '0;
    {wdg, cfg_long, ack, paddr, pwdata, errors, cmp_count} = '0;
    cfg_ls_en = 1'b1;
    cfg_thr = 2'h1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    run_wait;
    chk_rng(n_oe, 281);
    wdg_pulse;
    chk_rng(n_oe, 281);
    apb(0, `ICS_ADDR, 0, 32'h0000_0001, 0);
    apb(1, `ICS_ADDR, 0, 0, 0);
    $display("test watchdog done");
    ext_low <= 1'b1;
    repeat (3) @(posedge clk);
    ext_low <= 1'b0;
    run_wait;
    chk_rng(n_oe, 281);
    apb(0, `ICS_ADDR, 0, 32'h0000_0000, 0);
    cfg_long <= 1'b1;
    wdg_pulse;
    chk_rng(n_oe, 4121);
    cfg_long <= 1'b0;
    $display("test pin and delay done");
    ls_det <= 1'b1;
    repeat (300) @(posedge clk);
    chk({oe, cpu_rst, pin}, 32'h0000_0006);
    ls_det <= 1'b0;
    run_wait;
    chk_rng(n_oe, 256);
    apb(0, `ICS_ADDR, 0, 32'h0000_0010, 0);
    wdg_pulse;
    apb(0, `ICS_ADDR, 0, 32'h0000_0011, 0);
    apb(1, `ICS_ADDR, 0, 0, 0);
    $display("test low supply done");
    main_cmp <= 1'b1;
    repeat (8) @(posedge clk);
    chk(irq, 32'h0000_0000);
    apb(1, `ICS_ADDR, 32'h0000_0040, 0, 0);
    repeat (8) @(posedge clk);
    chk(irq, 32'h0000_0001);
    apb(0, `ICS_ADDR, 0, 32'h0000_0060, 0);
    ack_irq;
    main_cmp <= 1'b0;
    repeat (8) @(posedge clk);
    chk(irq, 32'h0000_0001);
    ack_irq;
    apb(1, `ICS_ADDR, 32'h0000_00c0, 0, 0);
    ext_cmp <= 1'b1;
    repeat (8) @(posedge clk);
    apb(0, `ICS_ADDR, 0, 32'h0000_00e0, 0);
    ack_irq;
    ext_cmp <= 1'b0;
    apb(1, `ICS_ADDR, 32'h0000_0040, 0, 0);
    ack_irq;
    cfg_ls_en <= 1'b0;
    main_cmp <= 1'b1;
    repeat (8) @(posedge clk);
    apb(0, `ICS_ADDR, 0, 32'h0000_0040, 0);
    chk(irq, 32'h0000_0000);
    main_cmp <= 1'b0;
    cfg_ls_en <= 1'b1;
    $display("test warning done");
    // Every threshold code is mirrored
    for (int i = 0; i < 4; i++) begin
      cfg_thr <= 2'(i);
      // Let the two-stage synchroniser settle before the mirror is read
      repeat (3) @(posedge clk);
      apb(0, `CFG_ADDR, 0, 32'h0000_0002 + 4 * i, 0);
    end
    apb(0, 12'h00c, 0, 32'h0000_0000, 1);
    $display("test config done");
    summarize;
  end
endmodule
bind reset_sequencer rsq_chk i_rsq_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .RST_PIN_OE_O(RST_PIN_OE_O), .CPU_RESET_O(CPU_RESET_O), .VEC_FETCH_O(VEC_FETCH_O),
  .VEC_ADDR_O(VEC_ADDR_O), .WDG_UNDERFLOW_I(WDG_UNDERFLOW_I), .LS_DET_I(LS_DET_I),
  .CFG_LS_EN_I(CFG_LS_EN_I), .WARN_IRQ_O(WARN_IRQ_O));
